// ### verilog/pgs_regs.sv
`timescale 1ns/1ps
module pgs_regs
    import pgs_pkg::*;
#(
    parameter int CYC_DLY_A = DELAY_A_MS * CYC_PER_MS,
    parameter int CYC_DLY_B = DELAY_B_MS * CYC_PER_MS,
    parameter int CYC_DLY_C = DELAY_C_MS * CYC_PER_MS,
    parameter int CYC_DLY_D = DELAY_D_MS * CYC_PER_MS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [RES_W-1:0] adc_result,
    input wire logic conversion_done_flag,
    input wire logic [RAIL_N-1:0] rail_in_range,
    input wire logic supply_below,
    output logic power_ok_pin_o,
    output logic power_ok_pin_oe_n,
    output logic reset_out_n
);

    // ==========================================
    // State
    typedef struct packed {
        logic [7:0] rdata_r;
        logic [RES_W-1:0] result_r;
        logic [1:0] delay_sel_r;
        logic [5:0] mask_r;
        logic [RAIL_N-1:0] rail_meta_r;
        logic [RAIL_N-1:0] rail_r;
        logic cmp_meta_r;
        logic cmp_r;
        logic [CNT_W-1:0] pg_cnt_r;
        logic [CNT_W-1:0] rst_cnt_r;
        logic pg_ok_r;
        logic rst_ok_r;
    } pgs_state_t;

    pgs_state_t st_r;
    pgs_state_t st_nxt;
    logic fault;
    logic [CNT_W-1:0] limit;

    // Delay length for the selected code
    function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] sel);
        unique case (pgs_delay_t'(sel))
            PGS_DLY_20: delay_cycles = CNT_W'(CYC_DLY_A);
            PGS_DLY_100: delay_cycles = CNT_W'(CYC_DLY_B);
            PGS_DLY_200: delay_cycles = CNT_W'(CYC_DLY_C);
            PGS_DLY_400: delay_cycles = CNT_W'(CYC_DLY_D);
        endcase
    endfunction : delay_cycles

    // ==========================================
    // Fault condition from mask and synchronised rails
    always_comb begin
        fault = |(st_r.mask_r[RAIL_N-1:0] & ~st_r.rail_r);
        if (st_r.mask_r[PAIR_MASK_BIT] && !st_r.rail_r[BUCK_THREE_BIT] && !st_r.rail_r[LIN_ONE_BIT]) begin
            fault = 1'b1;
        end
        limit = delay_cycles(st_r.delay_sel_r);
    end

    // ==========================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Two-stage synchronisers for analog comparator levels
        st_nxt.rail_meta_r = rail_in_range;
        st_nxt.rail_r = st_r.rail_meta_r;
        st_nxt.cmp_meta_r = supply_below;
        st_nxt.cmp_r = st_r.cmp_meta_r;
        // Capture a finished conversion; host waits up to 50 cycles for the flag before reading
        if (conversion_done_flag) begin
            st_nxt.result_r = adc_result;
        end
        // Register writes
        if (reg_wr && reg_addr == ADDR_RAIL_STATUS) begin
            st_nxt.delay_sel_r = reg_wdata[DLY_MSB:DLY_LSB];
        end
        if (reg_wr && reg_addr == ADDR_RAIL_MASK) begin
            st_nxt.mask_r = reg_wdata[PAIR_MASK_BIT:0];
        end
        // Register reads, unmapped reads return zero
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_RESULT_LOW: st_nxt.rdata_r = st_r.result_r[7:0];
                ADDR_RESULT_HIGH: st_nxt.rdata_r = {HIGH_ZERO, st_r.result_r[RES_W-1:8]};
                ADDR_RAIL_STATUS: st_nxt.rdata_r = {st_r.cmp_r, st_r.delay_sel_r, st_r.rail_r};
                ADDR_RAIL_MASK: st_nxt.rdata_r = {2'h0, st_r.mask_r};
                default: st_nxt.rdata_r = 8'h00;
            endcase
        end
        // Power-ok timer: fault drops pin at once, release after full delay
        if (fault) begin
            st_nxt.pg_cnt_r = '0;
            st_nxt.pg_ok_r = 1'b0;
        end else if (st_r.pg_cnt_r >= limit - CNT_W'(1)) begin
            st_nxt.pg_ok_r = 1'b1;
        end else begin
            st_nxt.pg_cnt_r = st_r.pg_cnt_r + CNT_W'(1);
        end
        // Reset output timer follows the supply comparator with the same delay
        if (st_r.cmp_r) begin
            st_nxt.rst_cnt_r = '0;
            st_nxt.rst_ok_r = 1'b0;
        end else if (st_r.rst_cnt_r >= limit - CNT_W'(1)) begin
            st_nxt.rst_ok_r = 1'b1;
        end else begin
            st_nxt.rst_cnt_r = st_r.rst_cnt_r + CNT_W'(1);
        end
    end

    // ==========================================
    // State register, defaults reload on lockout reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.rdata_r <= 8'h00;
            st_r.result_r <= RESULT_RESET;
            st_r.delay_sel_r <= DELAY_RESET;
            st_r.mask_r <= MASK_RESET;
            st_r.rail_meta_r <= 5'h00;
            st_r.rail_r <= 5'h00;
            st_r.cmp_meta_r <= 1'b1;
            st_r.cmp_r <= 1'b1;
            st_r.pg_cnt_r <= '0;
            st_r.rst_cnt_r <= '0;
            st_r.pg_ok_r <= 1'b0;
            st_r.rst_ok_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops, pin drive tied to constant low; open-drain pin only ever drives low
    assign reg_rdata = st_r.rdata_r;
    assign power_ok_pin_o = 1'b0;
    assign power_ok_pin_oe_n = st_r.pg_ok_r;
    assign reset_out_n = st_r.rst_ok_r;

    // ==========================================
    // Assertions
    a_result_low: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_RESULT_LOW |=> reg_rdata == $past(st_r.result_r[7:0]))
        else $error("low result byte wrong");
    a_result_high: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_RESULT_HIGH |=> reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] == $past(st_r.result_r[9:8]))
        else $error("high result byte wrong");
    a_comparator_bit: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_RAIL_STATUS |=> reg_rdata[CMP_BIT] == $past(st_r.cmp_r))
        else $error("comparator bit wrong");
    a_delay_write: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_RAIL_STATUS |=> st_r.delay_sel_r == $past(reg_wdata[6:5]))
        else $error("delay select not written");
    a_rail_status: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_RAIL_STATUS |=> reg_rdata[4:0] == $past(st_r.rail_r, 1))
        else $error("rail status bits wrong");
    a_mask_fault: assert property (@(posedge clk) disable iff (!reset_n)
        |(st_r.mask_r[4:0] & ~st_r.rail_r) |=> power_ok_pin_oe_n == 1'b0)
        else $error("masked rail fault did not pull pin low");
    a_pair_fault: assert property (@(posedge clk) disable iff (!reset_n)
        st_r.mask_r[5] && !st_r.rail_r[2] && !st_r.rail_r[1] |=> power_ok_pin_oe_n == 1'b0)
        else $error("paired fault did not pull pin low");
    a_pin_release: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(power_ok_pin_oe_n) |-> $past(st_r.pg_cnt_r) >= $past(limit) - CNT_W'(1) && !$past(fault))
        else $error("pin released before delay");

    // Register writes land only in the addressed fields
    a_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_RAIL_MASK |=> st_r.mask_r == $past(reg_wdata[PAIR_MASK_BIT:0]))
        else $error("mask not written");
    a_status_write_only: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_RAIL_STATUS |=> st_r.mask_r == $past(st_r.mask_r))
        else $error("status write touched the mask");
    a_delay_keep: assert property (@(posedge clk) disable iff (!reset_n)
        reg_wr && reg_addr == ADDR_RAIL_MASK |=> st_r.delay_sel_r == $past(st_r.delay_sel_r))
        else $error("mask write touched the delay");

    // Reads return the addressed fields, unmapped offsets above the mask register read zero
    a_delay_read: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_RAIL_STATUS |=> reg_rdata[DLY_MSB:DLY_LSB] == $past(st_r.delay_sel_r))
        else $error("delay field read wrong");
    a_mask_read: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_RAIL_MASK |=>
        reg_rdata[PAIR_MASK_BIT:0] == $past(st_r.mask_r) && reg_rdata[7:6] == 2'h0)
        else $error("mask read wrong");
    a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
        reg_rd && reg_addr > ADDR_RAIL_MASK |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    // Read data and the result hold between their strobes, so host writes cannot alter them
    a_rdata_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_result_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !conversion_done_flag |=> $stable(st_r.result_r))
        else $error("result changed without a conversion");

    // A released pin stays released while no enabled condition faults
    a_pin_stay: assert property (@(posedge clk) disable iff (!reset_n)
        power_ok_pin_oe_n && !fault |=> power_ok_pin_oe_n)
        else $error("pin pulled low without a fault");
    a_pair_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        power_ok_pin_oe_n && st_r.mask_r[RAIL_N-1:0] == '0 &&
        (st_r.rail_r[BUCK_THREE_BIT] || st_r.rail_r[LIN_ONE_BIT]) |=> power_ok_pin_oe_n)
        else $error("paired mask faulted with one rail in range");

    // Reset output follows the supply comparator and shares the selected delay
    a_reset_follow: assert property (@(posedge clk) disable iff (!reset_n)
        st_r.cmp_r |=> !reset_out_n)
        else $error("reset output high with supply low");
    a_reset_release: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(reset_out_n) |-> $past(st_r.rst_cnt_r) >= $past(limit) - CNT_W'(1) && !$past(st_r.cmp_r))
        else $error("reset output released before delay");
endmodule : pgs_regs

// ### common/pgs_pkg.sv
package pgs_pkg;
    // ==========================================
    // Clock and delay timing
    localparam int CLK_HZ = 200_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int DELAY_A_MS = 20;
    localparam int DELAY_B_MS = 100;
    localparam int DELAY_C_MS = 200;
    localparam int DELAY_D_MS = 400;
    localparam int CNT_W = 27;

    // ==========================================
    // Register offsets
    localparam logic [7:0] ADDR_RESULT_LOW = 8'h09;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'h0A;
    localparam logic [7:0] ADDR_RAIL_STATUS = 8'h0B;
    localparam logic [7:0] ADDR_RAIL_MASK = 8'h0C;

    // ==========================================
    // Field layout
    localparam int CMP_BIT = 7;
    localparam int DLY_LSB = 5;
    localparam int DLY_MSB = 6;
    localparam int PAIR_MASK_BIT = 5;
    localparam int RAIL_N = 5;
    localparam int BUCK_THREE_BIT = 2;
    localparam int LIN_ONE_BIT = 1;
    localparam int RES_W = 10;

    // ==========================================
    // Reset values
    localparam logic [1:0] DELAY_RESET = 2'h3;
    localparam logic [5:0] MASK_RESET = 6'h1C;
    localparam logic [RES_W-1:0] RESULT_RESET = 10'h000;
    localparam logic [5:0] HIGH_ZERO = 6'h00;

    // ==========================================
    // Delay select codes
    typedef enum logic [1:0] {
        PGS_DLY_20 = 2'b00,
        PGS_DLY_100 = 2'b01,
        PGS_DLY_200 = 2'b10,
        PGS_DLY_400 = 2'b11
    } pgs_delay_t;
endpackage : pgs_pkg

// ### verification/pgs_host.sv
`timescale 1ns/1ps
// ==========================================
// Host side of the register port
module pgs_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic conversion_done_flag
);
    // Idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One write strobe, then the bus shows inverted garbage
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
    endtask : wr
    // Read data is taken one cycle after the strobe
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        v = reg_rdata;
    endtask : rd
    // Both result bytes, fetched once the conversion is done or after a 50-cycle wait without the flag
    task rd_result(output logic [7:0] lo, output logic [7:0] hi, output logic ok);
        for (int i = 0; i < 50 && conversion_done_flag !== 1'b1; i++) @(negedge clk);
        ok = (conversion_done_flag === 1'b1);
        rd(8'h09, lo);
        rd(8'h0A, hi);
    endtask : rd_result
endmodule : pgs_host

// ### verification/pgs_regs_tb.sv
`timescale 1ns/1ps
// ==========================================
// Register bank bench
module pgs_regs_tb;
    import pgs_pkg::*;
    logic clk = 0, reset_n = 0, reg_wr, reg_rd, done = 0, below = 0, pin_o, oe_n, rst_o_n;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, h;
    logic ok;
    logic [RES_W-1:0] adc = 10'h000;
    logic [RAIL_N-1:0] rails = 5'h1F;
    int mismatches = 0, num_checks = 0;
    initial forever #2.5 clk = ~clk;
    pgs_regs #(.CYC_DLY_A(10), .CYC_DLY_B(20), .CYC_DLY_C(30), .CYC_DLY_D(40)) dut (.clk(clk),
        .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .adc_result(adc), .conversion_done_flag(done), .rail_in_range(rails),
        .supply_below(below), .power_ok_pin_o(pin_o), .power_ok_pin_oe_n(oe_n), .reset_out_n(rst_o_n));
    pgs_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conversion_done_flag(done));
    // Verdict and end of run
    task conclude;
        if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    // Bounded wait for the pin enable to reach a level
    task wait_oe(input logic exp, input int n);
        for (int i = 0; i < n && oe_n !== exp; i++) @(negedge clk);
        chk({7'h00, oe_n}, {7'h00, exp}, "pin level");
        if (oe_n !== exp) conclude();
    endtask : wait_oe
    // Bounded wait for the reset output to reach a level
    task wait_rst(input logic exp, input int n);
        for (int i = 0; i < n && rst_o_n !== exp; i++) @(negedge clk);
        chk({7'h00, rst_o_n}, {7'h00, exp}, "reset output level");
        if (rst_o_n !== exp) conclude();
    endtask : wait_rst
    // Outputs while reset or lockout is held
    task t_held;
        chk({7'h00, oe_n}, 8'h00, "pin held low");
        chk({7'h00, rst_o_n}, 8'h00, "reset output held");
        chk(reg_rdata, 8'h00, "read data cleared");
    endtask : t_held
    task t_reset;
        wait_oe(1'b1, 60);
        chk({7'h00, rst_o_n}, 8'h01, "reset output released");
        chk({7'h00, pin_o}, 8'h00, "pin drive level");
        host.rd(ADDR_RAIL_STATUS, d);
        chk(d, 8'h7F, "status default");
        host.rd(ADDR_RAIL_MASK, d);
        chk(d, 8'h1C, "mask default");
    endtask : t_reset
    task t_result;
        adc = 10'h2A5;
        done = 1'b1;
        host.rd_result(d, h, ok);
        done = 1'b0;
        chk({7'h00, ok}, 8'h01, "conversion wait");
        if (!ok) conclude();
        chk(d, 8'hA5, "result low");
        chk(h, 8'h02, "result high");
        adc = 10'h15A;
        host.wr(ADDR_RESULT_LOW, 8'h00);
        host.rd(ADDR_RESULT_LOW, d);
        chk(d, 8'hA5, "result written");
        host.rd(8'h20, d);
        chk(d, 8'h00, "unmapped read");
    endtask : t_result
    task t_status;
        below = 1'b1;
        rails = 5'h0A;
        repeat (4) @(negedge clk);
        host.rd(ADDR_RAIL_STATUS, d);
        chk(d, 8'hEA, "status live");
        chk({7'h00, rst_o_n}, 8'h00, "reset output with supply low");
        host.wr(ADDR_RAIL_STATUS, 8'h9F);
        host.rd(ADDR_RAIL_STATUS, d);
        chk(d, 8'h8A, "status write");
        below = 1'b0;
        rails = 5'h1F;
        // Shortest code: two sync edges plus ten cycles before release
        repeat (11) @(negedge clk);
        chk({7'h00, rst_o_n}, 8'h00, "reset output early release");
        wait_rst(1'b1, 2);
    endtask : t_status
    // Every delay code, timed on a single masked rail fault
    task t_delay;
        for (int c = 0; c < 4; c++) begin
            host.wr(ADDR_RAIL_STATUS, 8'(c << 5));
            host.rd(ADDR_RAIL_STATUS, d);
            chk(d, 8'(c << 5) | 8'h1F, "delay code");
            host.wr(ADDR_RAIL_MASK, 8'h10);
            wait_oe(1'b1, 60);
            rails = 5'h0F;
            wait_oe(1'b0, 5);
            rails = 5'h1F;
            // Release comes two sync edges plus the full delay after the rail recovers
            repeat (10 * (c + 1) + 1) @(negedge clk);
            chk({7'h00, oe_n}, 8'h00, "early release");
            wait_oe(1'b1, 2);
        end
    endtask : t_delay
    task t_mask;
        host.wr(ADDR_RAIL_MASK, 8'h00);
        rails = 5'h00;
        repeat (6) @(negedge clk);
        chk({7'h00, oe_n}, 8'h01, "unmasked rails");
        rails = 5'h1B;
        host.wr(ADDR_RAIL_MASK, 8'h20);
        repeat (6) @(negedge clk);
        chk({7'h00, oe_n}, 8'h01, "pair one bad");
        rails = 5'h19;
        wait_oe(1'b0, 5);
        rails = 5'h1F;
    endtask : t_mask
    // Lockout in mid-run reloads every default
    task t_lockout;
        host.wr(ADDR_RAIL_STATUS, 8'h00);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        t_held();
        reset_n = 1'b1;
        t_reset();
    endtask : t_lockout
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        t_held();
        reset_n = 1'b1;
        t_reset();
        t_result();
        t_status();
        t_delay();
        t_mask();
        t_lockout();
        conclude();
    end
endmodule : pgs_regs_tb
